// ### hw/amc_ctrl.sv
/*
  Mode and calibration control: serial control word, data register and
  per-channel zero and full scale coefficients, with data-ready signalling.
  Assumes host pins are asynchronous to ref_clk and slower than it by far;
  the host changes write data and samples read data before the
  rising sclk edge, and the front end answers each measStart once.
*/
`timescale 1ns/100ps
`default_nettype none
`include "amc_regs.svh"

module amc_ctrl
  import amc_pkg::*;
#(
  parameter int CHANNELS = 2
)(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire amc_pins_s   pins,
  output var  logic        sdataOut,
  output var  logic        sdataOe,
  output var  logic        data_ready_n,
  output var  logic        measStart,
  output var  amc_src_e    measSource,
  input  wire logic        measDone,
  input  wire logic [23:0] measData,
  output var  logic [7:0]  pgaGain,
  output var  logic        channel_select,
  output var  logic        powerDown,
  output var  logic [11:0] notchCode
);

  // Pin synchronisers and edge history
  amc_pins_s pinMeta, pinSync, pinPrev;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pinMeta <= '{sclk: 1'b0, tfsN: 1'b1, rfsN: 1'b1, sdataIn: 1'b0, registerSelectPin: 1'b0};
      pinSync <= '{sclk: 1'b0, tfsN: 1'b1, rfsN: 1'b1, sdataIn: 1'b0, registerSelectPin: 1'b0};
      pinPrev <= '{sclk: 1'b0, tfsN: 1'b1, rfsN: 1'b1, sdataIn: 1'b0, registerSelectPin: 1'b0};
    end else begin
      pinMeta <= pins;
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  // Edge strobes
  wire sclkRise = pinSync.sclk & ~pinPrev.sclk;
  wire tfsFall  = ~pinSync.tfsN & pinPrev.tfsN;
  wire tfsRise  = pinSync.tfsN & ~pinPrev.tfsN;
  wire rfsFall  = ~pinSync.rfsN & pinPrev.rfsN;
  wire rfsRise  = pinSync.rfsN & ~pinPrev.rfsN;

  // Control word and its fields
  logic [23:0] cfg;
  amc_mode_e   cfgMode;
  assign cfgMode = amc_mode_e'(cfg[`AMC_MODE_MSB:`AMC_MODE_LSB]);
  wire cfgChan  = cfg[`AMC_CHAN_BIT];
  wire cfgWlen  = cfg[`AMC_WLEN_BIT];
  wire zsAccess = (cfgMode == AMC_MD_ZSACC);
  wire fsAccess = (cfgMode == AMC_MD_FSACC);

  // Receive shifter
  logic [23:0] rxShift;
  logic [4:0]  rxCount;
  logic        rxSel;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rxShift <= 24'h000000;
      rxCount <= 5'h00;
      rxSel   <= 1'b0;
    end else if (tfsFall) begin
      rxCount <= 5'h00;
      rxSel   <= pinSync.registerSelectPin;
    end else if (sclkRise && !pinSync.tfsN && rxCount < `AMC_FULL_LEN) begin
      rxShift <= {rxShift[22:0], pinSync.sdataIn};
      rxCount <= rxCount + 5'h01;
    end
  end

  // Write commits at frame end only with all 24 bits
  wire rxFull   = (rxCount == `AMC_FULL_LEN);
  wire cfgWrite = tfsRise && rxFull && !rxSel;
  wire zsWrite  = tfsRise && rxFull && rxSel && zsAccess;
  wire fsWrite  = tfsRise && rxFull && rxSel && fsAccess;

  // Sequencer outputs
  logic        seqZero, seqFull, seqResult, seqCalDone;
  logic [23:0] seqData;

  amc_meas_seq u_seq (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .start       (cfgWrite),
    .startMode   (amc_mode_e'(rxShift[`AMC_MODE_MSB:`AMC_MODE_LSB])),
    .measDone    (measDone),
    .measData    (measData),
    .measStart   (measStart),
    .measSource  (measSource),
    .coefWrZero  (seqZero),
    .coefWrFull  (seqFull),
    .resultValid (seqResult),
    .calDone     (seqCalDone),
    .resultData  (seqData)
  );

  // Control word: host load, hardware return to normal
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cfg <= `AMC_CFG_RESET;
    end else if (cfgWrite) begin
      cfg <= rxShift;
    end else if (seqCalDone) begin
      cfg[`AMC_MODE_MSB:`AMC_MODE_LSB] <= AMC_MD_NORMAL;
    end
  end

  // Per-channel coefficient storage
  logic [23:0] zsCoef [CHANNELS];
  logic [23:0] fsCoef [CHANNELS];
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_coef
    wire chSel = (cfgChan == 1'(ch));
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        zsCoef[ch] <= `AMC_ZS_RESET;
        fsCoef[ch] <= `AMC_FS_RESET;
      end else begin
        if (chSel && zsWrite) begin
          zsCoef[ch] <= rxShift;
        end else if (chSel && seqZero) begin
          zsCoef[ch] <= seqData;
        end
        if (chSel && fsWrite) begin
          fsCoef[ch] <= rxShift;
        end else if (chSel && seqFull) begin
          fsCoef[ch] <= seqData;
        end
      end
    end
  end

  // Conversion result register
  logic [23:0] dataWord;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dataWord <= `AMC_DATA_RESET;
    end else if (seqResult) begin
      dataWord <= seqData;
    end
  end

  // Read source and length at frame start
  wire         coefRead = pinSync.registerSelectPin && (zsAccess || fsAccess);
  wire         dataRead = pinSync.registerSelectPin && !coefRead;
  wire [23:0]  readWord = !pinSync.registerSelectPin ? cfg :
                          zsAccess ? zsCoef[cfgChan] :
                          fsAccess ? fsCoef[cfgChan] : dataWord;
  wire [4:0]   readLen  = (dataRead && !cfgWlen) ? `AMC_SHORT_LEN :
                          `AMC_FULL_LEN;
  wire         readOk   = !dataRead || !data_ready_n;

  // Transmit shifter
  logic [23:0] txShift;
  logic [4:0]  txCount;
  logic [4:0]  txLen;
  logic        txData;
  wire         txLast = sdataOe && sclkRise && (txCount + 5'h01 == txLen);
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      txShift  <= 24'h000000;
      txCount  <= 5'h00;
      txLen    <= `AMC_FULL_LEN;
      txData   <= 1'b0;
      sdataOut <= 1'b0;
      sdataOe  <= 1'b0;
    end else if (rfsFall) begin
      txShift  <= {readWord[22:0], 1'b0};
      sdataOut <= readWord[23];
      txCount  <= 5'h00;
      txLen    <= readLen;
      txData   <= dataRead;
      sdataOe  <= readOk;
    end else if (rfsRise) begin
      sdataOe  <= 1'b0;
    end else if (sdataOe && sclkRise && txCount < txLen) begin
      sdataOut <= txShift[23];
      txShift  <= {txShift[22:0], 1'b0};
      txCount  <= txCount + 5'h01;
    end
  end

  // Data ready: new word or calibration end wins over read completion
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      data_ready_n <= 1'b1;
    end else if (seqResult || seqCalDone) begin
      data_ready_n <= 1'b0;
    end else if (txLast && txData) begin
      data_ready_n <= 1'b1;
    end
  end

  // Front end settings
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pgaGain        <= 8'h01;
      channel_select <= 1'b0;
      powerDown      <= 1'b0;
      notchCode      <= 12'h000;
    end else begin
      pgaGain        <= 8'h01 << cfg[`AMC_GAIN_MSB:`AMC_GAIN_LSB];
      channel_select <= cfgChan;
      powerDown      <= cfg[`AMC_PDOWN_BIT];
      notchCode      <= cfg[`AMC_NOTCH_MSB:`AMC_NOTCH_LSB];
    end
  end

endmodule
`default_nettype wire

// ### hw/amc_regs.svh
/*
  Constants of the mode and calibration control block: control word field
  positions, reset values, transfer lengths and background slot counts.
  Assumes it is included by bare name from the package and the modules.
*/
`ifndef AMC_REGS_SVH
`define AMC_REGS_SVH

// Control word field positions
`define AMC_MODE_MSB      23
`define AMC_MODE_LSB      21
`define AMC_GAIN_MSB      20
`define AMC_GAIN_LSB      18
`define AMC_CHAN_BIT      17
`define AMC_PDOWN_BIT     16
`define AMC_WLEN_BIT      15
`define AMC_NOTCH_MSB     11
`define AMC_NOTCH_LSB     0

// Reset values
`define AMC_CFG_RESET     24'h000000
`define AMC_ZS_RESET      24'h000000
`define AMC_FS_RESET      24'h800000
`define AMC_DATA_RESET    24'h000000

// Transfer lengths in serial clocks
`define AMC_FULL_LEN      5'h18
`define AMC_SHORT_LEN     5'h10

// Background calibration: measurement slots per output word
`define AMC_BG_SLOTS      3'h6

`endif

// ### hw/amc_pkg.sv
/*
  Types of the mode and calibration control block: operating modes,
  measurement sources, sequencer states and the serial pin bundle.
  Assumes the constants header is on the include path.
*/
`include "amc_regs.svh"

package amc_pkg;

  // Operating mode field codes
  typedef enum logic [2:0] {
    AMC_MD_NORMAL  = 3'b000,
    AMC_MD_SELF    = 3'b001,
    AMC_MD_SYSZERO = 3'b010,
    AMC_MD_SYSFULL = 3'b011,
    AMC_MD_SYSOFF  = 3'b100,
    AMC_MD_BACKGND = 3'b101,
    AMC_MD_ZSACC   = 3'b110,
    AMC_MD_FSACC   = 3'b111
  } amc_mode_e;

  // What the converter front end measures
  typedef enum logic [1:0] {
    AMC_SRC_INPUT  = 2'b00,
    AMC_SRC_SHORT  = 2'b01,
    AMC_SRC_REF    = 2'b10
  } amc_src_e;

  // Sequencer states
  typedef enum logic [1:0] {
    AMC_SQ_ISSUE   = 2'b00,
    AMC_SQ_WAIT    = 2'b01
  } amc_seq_e;

  // Serial port pins as seen by the device
  typedef struct packed {
    logic sclk;
    logic tfsN;
    logic rfsN;
    logic sdataIn;
    logic registerSelectPin;
  } amc_pins_s;

endpackage

// ### hw/amc_meas_seq.sv
/*
  Measurement sequencer: issues conversions to the front end and turns
  their results into data words or calibration coefficients per mode.
  Assumes the front end answers each measStart with exactly one measDone.
*/
`timescale 1ns/100ps
`default_nettype none
`include "amc_regs.svh"

module amc_meas_seq
  import amc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire amc_mode_e   startMode,
  input  wire logic        measDone,
  input  wire logic [23:0] measData,
  output var  logic        measStart,
  output var  amc_src_e    measSource,
  output var  logic        coefWrZero,
  output var  logic        coefWrFull,
  output var  logic        resultValid,
  output var  logic        calDone,
  output var  logic [23:0] resultData
);

  amc_seq_e  state;
  amc_mode_e mode;
  logic [2:0] step;
  logic       discard;

  // Source of the current step and what its result feeds
  amc_src_e   stepSrc;
  logic       stepZero, stepFull, stepData, stepLast;
  logic [2:0] next_step;
  always_comb begin
    stepSrc  = AMC_SRC_INPUT;
    stepZero = 1'b0;
    stepFull = 1'b0;
    stepData = 1'b0;
    stepLast = 1'b0;
    next_step = 3'h0;
    unique case (mode)
      AMC_MD_SELF: begin
        stepSrc  = (step == 3'h0) ? AMC_SRC_SHORT : AMC_SRC_REF;
        stepZero = (step == 3'h0);
        stepFull = (step != 3'h0);
        stepLast = (step != 3'h0);
        next_step = 3'h1;
      end
      AMC_MD_SYSZERO: begin
        stepZero = 1'b1;
        stepLast = 1'b1;
      end
      AMC_MD_SYSFULL: begin
        stepFull = 1'b1;
        stepLast = 1'b1;
      end
      AMC_MD_SYSOFF: begin
        stepSrc  = (step == 3'h0) ? AMC_SRC_INPUT : AMC_SRC_REF;
        stepZero = (step == 3'h0);
        stepFull = (step != 3'h0);
        stepLast = (step != 3'h0);
        next_step = 3'h1;
      end
      AMC_MD_BACKGND: begin
        // Six slots per word: input, short settle/measure, ref settle/measure, input settle
        stepSrc  = (step == 3'h0 || step == 3'h5) ? AMC_SRC_INPUT :
                   (step < 3'h3) ? AMC_SRC_SHORT : AMC_SRC_REF;
        stepData = (step == 3'h0);
        stepZero = (step == 3'h2);
        stepFull = (step == 3'h4);
        next_step = (step == `AMC_BG_SLOTS - 3'h1) ? 3'h0 : step + 3'h1;
      end
      default: begin
        stepData = 1'b1;
      end
    endcase
  end

  wire useResult = (state == AMC_SQ_WAIT) && measDone && !discard && !start;

  // Issue, wait, act on result
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state       <= AMC_SQ_ISSUE;
      mode        <= AMC_MD_NORMAL;
      step        <= 3'h0;
      discard     <= 1'b0;
      measStart   <= 1'b0;
      measSource  <= AMC_SRC_INPUT;
      coefWrZero  <= 1'b0;
      coefWrFull  <= 1'b0;
      resultValid <= 1'b0;
      calDone     <= 1'b0;
      resultData  <= `AMC_DATA_RESET;
    end else begin
      measStart   <= 1'b0;
      coefWrZero  <= useResult && stepZero;
      coefWrFull  <= useResult && stepFull;
      resultValid <= useResult && stepData;
      calDone     <= useResult && stepLast;
      if (measDone) begin
        resultData <= measData;
      end
      if (start) begin
        mode    <= startMode;
        step    <= 3'h0;
        discard <= (state == AMC_SQ_WAIT) && !measDone;
        state   <= (state == AMC_SQ_WAIT && !measDone) ? AMC_SQ_WAIT : AMC_SQ_ISSUE;
      end else if (state == AMC_SQ_ISSUE) begin
        measStart  <= 1'b1;
        measSource <= stepSrc;
        state      <= AMC_SQ_WAIT;
      end else if (measDone) begin
        state   <= AMC_SQ_ISSUE;
        discard <= 1'b0;
        if (!discard) begin
          step <= stepLast ? 3'h0 : next_step;
          if (stepLast) begin
            mode <= AMC_MD_NORMAL;
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### verification/amc_ctrl_props.sv
/* Port checker for amc_ctrl.
   Assumes it is bound to amc_ctrl and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module amc_ctrl_props
  import amc_pkg::*;
#(
  parameter int CHANNELS = 2
)(
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire amc_pins_s   pins,
  input wire logic        sdataOut,
  input wire logic        sdataOe,
  input wire logic        data_ready_n,
  input wire logic        measStart,
  input wire amc_src_e    measSource,
  input wire logic        measDone,
  input wire logic [23:0] measData,
  input wire logic [7:0]  pgaGain,
  input wire logic        channel_select,
  input wire logic        powerDown,
  input wire logic [11:0] notchCode
);
  logic [3:0] sinceWr;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Cycles since the write frame closed
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sinceWr <= 4'hF;
    end else if (!pins.tfsN) begin
      sinceWr <= 4'h0;
    end else if (sinceWr != 4'hF) begin
      sinceWr <= sinceWr + 4'h1;
    end
  end
  // Control read frame held open, control outputs moving
  sequence s_ctl_open;
    pins.rfsN ##1 (!pins.rfsN && !pins.registerSelectPin) [*5];
  endsequence
  sequence s_ctl_move;
    $changed(pgaGain) || $changed(channel_select) || $changed(notchCode)
      || $changed(powerDown);
  endsequence
  a_gain_onehot: assert property ($onehot(pgaGain))
    else $error("gain not one-hot");
  a_ctl_late: assert property (s_ctl_move |-> sinceWr inside {[4'h1:4'hA]})
    else $error("control outputs moved without a write");
  a_data_ready_n_cause: assert property ($fell(data_ready_n) |-> $past(measDone, 2))
    else $error("data ready fell without a result");
  a_data_ready_n_release: assert property ($rose(data_ready_n) |-> $past(sdataOe))
    else $error("data ready rose without a read");
  a_ctl_drive: assert property (s_ctl_open |-> ##[0:2] sdataOe)
    else $error("control read not driven");
  a_oe_close: assert property ($fell(sdataOe) |-> $past(pins.rfsN, 2))
    else $error("data line released inside a read");
  a_start_pulse: assert property (measStart |=> !measStart)
    else $error("start pulse too long");
  a_src_hold: assert property (!measStart |-> $stable(measSource))
    else $error("source moved without a start");
endmodule
bind amc_ctrl amc_ctrl_props #(.CHANNELS(CHANNELS)) i_props (
  .ref_clk, .reset, .pins, .sdataOut, .sdataOe, .data_ready_n, .measStart,
  .measSource, .measDone, .measData, .pgaGain, .channel_select, .powerDown, .notchCode
);
`default_nettype wire

// ### verification/amc_front_model.sv
/* Front-end model: answers each start once, in order, after a delay.
   Assumes the bench sets the delay and the input value. */
`timescale 1ns/100ps
`default_nettype none
module amc_front_model
  import amc_pkg::*;
#(
  parameter logic [23:0] SHORT_VAL = 24'h000123,
  parameter logic [23:0] REF_VAL   = 24'h7ABCDE
)(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        measStart,
  input  wire amc_src_e    measSource,
  input  wire logic [8:0]  delay,
  input  wire logic [23:0] inputValue,
  output var  logic        measDone,
  output var  logic [23:0] measData
);
  int          dueQ[$];
  logic [23:0] valQ[$];
  int          now;
  // Pending measurements; data line scrambles outside a result
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dueQ.delete();
      valQ.delete();
      now = 0;
      measDone <= 1'b0;
      measData <= 24'h000000;
    end else begin
      now++;
      measDone <= 1'b0;
      measData <= ~measData;
      if (dueQ.size() > 0 && dueQ[0] <= now) begin
        measDone <= 1'b1;
        measData <= valQ.pop_front();
        void'(dueQ.pop_front());
      end
      if (measStart) begin
        dueQ.push_back(now + int'(delay));
        valQ.push_back(measSource == AMC_SRC_SHORT ? SHORT_VAL :
                       measSource == AMC_SRC_REF ? REF_VAL : inputValue);
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
/* Self-checking bench for amc_ctrl driving host serial frames.
   Assumes the checker is bound and the front-end model is compiled. */
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import amc_pkg::*;
;
  localparam logic [23:0] SH = 24'h000123;
  localparam logic [23:0] RF = 24'h7ABCDE;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        sclk = 1'b0, tfsN = 1'b1, rfsN = 1'b1, hostBit = 1'b0, sel = 1'b0;
  logic [8:0]  delay = 9'h0C8;
  logic [23:0] inVal = 24'h000000;
  amc_pins_s   pins;
  logic        sdataOut, sdataOe, data_ready_n, measStart, measDone;
  logic        channel_select, powerDown;
  amc_src_e    measSource;
  logic [23:0] measData;
  logic [7:0]  pgaGain;
  logic [11:0] notchCode;
  int          failures = 0;
  int          checks_done = 0;
  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;
  // Data line: device, host inside a write frame, else undriven shows inverse
  assign pins = '{sclk, tfsN, rfsN, sdataOe ? sdataOut : (tfsN ? ~hostBit : hostBit), sel};
  amc_ctrl i_dut (.ref_clk, .reset, .pins, .sdataOut, .sdataOe, .data_ready_n,
    .measStart, .measSource, .measDone, .measData, .pgaGain, .channel_select,
    .powerDown, .notchCode);
  amc_front_model #(.SHORT_VAL(SH), .REF_VAL(RF)) i_front (.ref_clk, .reset,
    .measStart, .measSource, .delay, .inputValue(inVal), .measDone, .measData);
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  function automatic logic [23:0] cw(input logic [2:0] md, input logic [2:0] g,
                                     input logic ch, input logic wl);
    return {md, g, ch, 1'b0, wl, 3'b000, 12'h5A3};
  endfunction
  // One frame, MSB first; read bits sampled while sclk is low
  task automatic xfer(input logic rd, input logic s, input int n,
                      input logic [23:0] w, output logic [23:0] r);
    int i;
    r = 24'h000000;
    sel = s;
    if (rd) rfsN = 1'b0;
    else tfsN = 1'b0;
    cyc(4);
    for (i = 0; i < n; i++) begin
      hostBit = (i < 24) ? w[23 - i] : 1'b1;
      cyc(5);
      r = {r[22:0], pins.sdataIn};
      sclk = 1'b1;
      cyc(5);
      sclk = 1'b0;
    end
    cyc(5);
    tfsN = 1'b1;
    rfsN = 1'b1;
    cyc(8);
  endtask
  task automatic wr(input logic s, input int n, input logic [23:0] w);
    logic [23:0] d;
    xfer(1'b0, s, n, w, d);
  endtask
  task automatic rdw(input logic s, input int n, output logic [23:0] r);
    xfer(1'b1, s, n, 24'h000000, r);
  endtask
  task automatic wait_rdy(input int lim);
    int i;
    for (i = 0; i < lim && data_ready_n !== 1'b0; i++)
      cyc(1);
  endtask
  task automatic coefs(input logic [23:0] z, input logic [23:0] f);
    logic [23:0] r;
    wr(1'b0, 24, cw(3'h6, 3'h0, 1'b0, 1'b0));
    rdw(1'b1, 24, r);
    check(r, z);
    wr(1'b0, 24, cw(3'h7, 3'h0, 1'b0, 1'b0));
    rdw(1'b1, 24, r);
    check(r, f);
  endtask
  task automatic t_reset();
    logic [23:0] r;
    rdw(1'b0, 24, r);
    check(r, 24'h000000);
    check({15'h0, pgaGain, channel_select}, 24'h000002);
  endtask
  task automatic t_gain();
    logic [23:0] r;
    int g;
    for (g = 0; g < 8; g++) begin
      wr(1'b0, 24, cw(3'h0, g[2:0], g[0], 1'b0));
      check({15'h0, pgaGain, channel_select}, {15'h0, 8'h01 << g, g[0]});
    end
    wr(1'b0, 20, cw(3'h0, 3'h2, 1'b0, 1'b1));
    check({16'h0, pgaGain}, 24'h000080);
    wr(1'b0, 30, cw(3'h0, 3'h5, 1'b0, 1'b1) | 24'h010000);
    rdw(1'b0, 24, r);
    check(r, cw(3'h0, 3'h5, 1'b0, 1'b1) | 24'h010000);
    check({12'h0, notchCode}, 24'h0005A3);
    check({23'h0, powerDown}, 24'h000001);
  endtask
  task automatic t_coef();
    logic [23:0] r;
    int k;
    for (k = 0; k < 2; k++) begin
      wr(1'b0, 24, cw(3'h6 + 3'(k), 3'h0, k[0], 1'b0));
      wr(1'b1, 24, 24'h13579B ^ 24'(k));
      wr(1'b1, 16, 24'hFFFF00);
      rdw(1'b1, 24, r);
      check(r, 24'h13579B ^ 24'(k));
    end
  endtask
  task automatic t_cal();
    logic [2:0]  md[4] = '{3'h1, 3'h2, 3'h3, 3'h4};
    logic [23:0] iv[4] = '{24'h0A0A0A, 24'h0A0A0A, 24'h0B0B0B, 24'h0C0C0C};
    logic [23:0] ez[4] = '{SH, 24'h0A0A0A, 24'h0A0A0A, 24'h0C0C0C};
    logic [23:0] ef[4] = '{RF, RF, 24'h0B0B0B, RF};
    logic [23:0] r;
    int k;
    for (k = 0; k < 4; k++) begin
      inVal = iv[k];
      wr(1'b0, 24, cw(md[k], 3'h0, 1'b0, 1'b0));
      rdw(1'b1, 16, r);
      wait_rdy(1500);
      check({23'h0, data_ready_n}, 24'h000000);
      rdw(1'b0, 24, r);
      check({21'h0, r[23:21]}, 24'h000000);
      coefs(ez[k], ef[k]);
    end
  endtask
  task automatic t_bg();
    amc_src_e pat[6] = '{AMC_SRC_SHORT, AMC_SRC_SHORT, AMC_SRC_REF, AMC_SRC_REF,
                         AMC_SRC_INPUT, AMC_SRC_INPUT};
    amc_src_e src[20];
    int i, j, n;
    delay = 9'h003;
    // Seed full scale away from the reference so a refresh is visible
    wr(1'b0, 24, cw(3'h7, 3'h0, 1'b0, 1'b0));
    wr(1'b1, 24, 24'h111111);
    wr(1'b0, 24, cw(3'h5, 3'h0, 1'b0, 1'b0));
    for (i = 0; i < 20; i++) begin
      for (n = 0; n < 100 && measStart !== 1'b1; n++)
        cyc(1);
      src[i] = measSource;
      cyc(1);
    end
    for (j = 1; j < 7; j++)
      if (src[j] == AMC_SRC_SHORT && src[j - 1] == AMC_SRC_INPUT) break;
    for (i = 0; i < 12; i++)
      check({22'h0, src[j + i]}, {22'h0, pat[i % 6]});
    coefs(SH, RF);
  endtask
  task automatic t_wlen();
    logic [23:0] r;
    int w;
    delay = 9'h1F0;
    inVal = 24'hA5C3F0;
    for (w = 0; w < 2; w++) begin
      wr(1'b0, 24, cw(3'h0, 3'h0, 1'b0, w[0]));
      rdw(1'b1, 24, r);
      wait_rdy(1200);
      rdw(1'b1, 16 + 8 * w, r);
      check(r, w[0] ? 24'hA5C3F0 : 24'h00A5C3);
      check({23'h0, data_ready_n}, 24'h000001);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    #2;
    reset = 1'b0;
    cyc(3);
    t_reset();
    t_gain();
    t_coef();
    t_cal();
    t_bg();
    t_wlen();
    print_verdict();
  end
  // Watchdog at several times the expected run
  initial begin
    #1000000;
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire
